/* File: src/olu_primary_regs.sv */
// primary control and status register bank of the eight channel line unit
`include "olu_defs.svh"
`default_nettype none

module olu_primary_regs
	import olu_pkg::*;
#(
	parameter logic [7:0] REVISION_CODE = `OLU_REV_DEFAULT // arbitrary value
)
(
	input  wire logic       CLK_SYS,
	input  wire logic       RST,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] LOS_IN,
	input  wire logic [7:0] SHORT_IN,
	output var  logic [7:0] REG_RDATA,
	output var  logic       REG_RVALID,
	output var  logic [7:0] ANALOG_LB,
	output var  logic [7:0] REMOTE_LB,
	output var  logic [7:0] DIGITAL_LB,
	output var  logic [7:0] TX_ALL_ONES,
	output var  logic [7:0] ALARM_ETSI,
	output var  logic       MON_RX_EN,
	output var  logic       MON_TX_EN,
	output var  logic [2:0] MON_CH,
	output var  logic       SOFT_RST_BUSY
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	olu_chan_t                 analog_loopback_ctl_ff;
	olu_chan_t                 remote_loopback_ctl_ff;
	olu_chan_t                 all_ones_send_ctl_ff;
	olu_chan_t                 digital_loopback_ctl_ff;
	olu_chan_t                 alarm_criteria_select_ff;
	olu_chan_t                 auto_all_ones_ctl_ff;
	olu_chan_t                 signal_absent_mask_ff;
	olu_chan_t                 line_short_mask_ff;
	olu_chan_t                 signal_absent_status_ff;
	olu_chan_t                 line_short_status_ff;
	olu_chan_t                 signal_absent_irq_ff;
	olu_chan_t                 line_short_irq_ff;
	logic [`OLU_MC_W-1:0]      monitor_point_select_ff;
	logic [7:0]                bank_pointer_ff;
	logic [7:0]                rdata_ff;
	logic                      rvalid_ff;
	olu_chan_t                 tx_ones_ff;
	logic                      mon_rx_ff;
	logic                      mon_tx_ff;
	logic [2:0]                mon_ch_ff;
	logic [7:0]                nxt_rdata;
	olu_mon_kind_t             nxt_mon_kind;
	logic                      srst;
	logic                      prim_sel;
	logic                      wr_acc;
	logic                      rd_acc;
	logic                      prim_wr;
	logic                      prim_rd;
	logic                      rd_abs;
	logic                      rd_short;
	olu_chan_t                 abs_set;
	olu_chan_t                 short_set;

	olu_rst_if rst_if ();

	// ------------------------------------------------------------------
	// soft reset timer
	// ------------------------------------------------------------------
	olu_srst_tmr u_srst_tmr (
		.clk_sys (CLK_SYS),
		.rst     (RST),
		.rif     (rst_if.tmr)
	);

	// ------------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------------
	// accesses during the soft reset window have no effect; reads are still answered, with zero data
	assign srst     = rst_if.busy;
	assign prim_sel = (bank_pointer_ff == `OLU_BANK_PRIMARY);
	assign wr_acc   = REG_WR && !srst;
	assign rd_acc   = REG_RD && !srst;
	assign prim_wr  = wr_acc && prim_sel;
	assign prim_rd  = rd_acc && prim_sel;
	assign rd_abs   = prim_rd && (REG_ADDR == `OLU_OFF_ABS_ST);
	assign rd_short = prim_rd && (REG_ADDR == `OLU_OFF_SHORT_ST);
	// any write to the soft reset offset while the primary bank is selected, whatever the data; the register itself never changes
	assign rst_if.start = prim_wr
		&& (REG_ADDR == `OLU_OFF_SRST);

	// ------------------------------------------------------------------
	// host writable control registers
	// ------------------------------------------------------------------
	// soft reset returns each one to its default, like power up
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST || srst) begin
			analog_loopback_ctl_ff   <= `OLU_RST_ZERO;
			remote_loopback_ctl_ff   <= `OLU_RST_ZERO;
			all_ones_send_ctl_ff     <= `OLU_RST_ZERO;
			digital_loopback_ctl_ff  <= `OLU_RST_ZERO;
			alarm_criteria_select_ff <= `OLU_RST_ZERO;
			auto_all_ones_ctl_ff     <= `OLU_RST_ZERO;
			signal_absent_mask_ff    <= `OLU_RST_ZERO;
			line_short_mask_ff       <= `OLU_RST_ZERO;
			monitor_point_select_ff  <= '0;
		end else if (prim_wr) begin
			unique case (REG_ADDR)
				`OLU_OFF_ALB:        analog_loopback_ctl_ff   <= REG_WDATA;
				`OLU_OFF_RLB:        remote_loopback_ctl_ff   <= REG_WDATA;
				`OLU_OFF_ONES:       all_ones_send_ctl_ff     <= REG_WDATA;
				`OLU_OFF_DLB:        digital_loopback_ctl_ff  <= REG_WDATA;
				`OLU_OFF_CRIT:       alarm_criteria_select_ff <= REG_WDATA;
				`OLU_OFF_AUTO_ONES:  auto_all_ones_ctl_ff     <= REG_WDATA;
				`OLU_OFF_ABS_MASK:   signal_absent_mask_ff    <= REG_WDATA;
				`OLU_OFF_SHORT_MASK: line_short_mask_ff       <= REG_WDATA;
				// upper nibble is reserved and not stored
				`OLU_OFF_MON: monitor_point_select_ff <= REG_WDATA[3:0];
				default: ;
			endcase
		end
	end

	// bank pointer; any value but the primary one hides this bank
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST || srst) begin
			bank_pointer_ff <= `OLU_BANK_PRIMARY;
		end else if (wr_acc && REG_ADDR == `OLU_OFF_BANK_PTR) begin
			bank_pointer_ff <= REG_WDATA;
		end
	end

	// ------------------------------------------------------------------
	// status capture
	// ------------------------------------------------------------------
	// one flop of delay; inputs already sit on this clock
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST || srst) begin
			signal_absent_status_ff <= `OLU_RST_ZERO;
			line_short_status_ff    <= `OLU_RST_ZERO;
		end else begin
			signal_absent_status_ff <= LOS_IN;
			line_short_status_ff    <= SHORT_IN;
		end
	end

	// ------------------------------------------------------------------
	// interrupt flags
	// ------------------------------------------------------------------
	// both edges count; the mask only gates new events
	assign abs_set   = (LOS_IN ^ signal_absent_status_ff)
		& signal_absent_mask_ff;
	assign short_set = (SHORT_IN ^ line_short_status_ff)
		& line_short_mask_ff;

	// per channel flags; a set in the clearing read cycle wins
	for (genvar g = 0; g < `OLU_NCH; g++) begin : g_flag
		always_ff @(posedge CLK_SYS or posedge RST) begin
			if (RST || srst) begin
				signal_absent_irq_ff[g] <= 1'b0;
			end else if (abs_set[g]) begin
				signal_absent_irq_ff[g] <= 1'b1;
			end else if (rd_abs) begin
				signal_absent_irq_ff[g] <= 1'b0;
			end
		end

		always_ff @(posedge CLK_SYS or posedge RST) begin
			if (RST || srst) begin
				line_short_irq_ff[g] <= 1'b0;
			end else if (short_set[g]) begin
				line_short_irq_ff[g] <= 1'b1;
			end else if (rd_short) begin
				line_short_irq_ff[g] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------
	// unmapped, write only and hidden-bank reads return zero
	always_comb begin
		nxt_rdata = `OLU_RST_ZERO;
		if (rd_acc && REG_ADDR == `OLU_OFF_BANK_PTR) begin
			nxt_rdata = bank_pointer_ff;
		end else if (prim_rd) begin
			unique case (REG_ADDR)
				`OLU_OFF_REV:        nxt_rdata = REVISION_CODE;
				`OLU_OFF_ALB:        nxt_rdata = analog_loopback_ctl_ff;
				`OLU_OFF_RLB:        nxt_rdata = remote_loopback_ctl_ff;
				`OLU_OFF_ONES:       nxt_rdata = all_ones_send_ctl_ff;
				`OLU_OFF_ABS_ST:     nxt_rdata = signal_absent_status_ff;
				`OLU_OFF_SHORT_ST:   nxt_rdata = line_short_status_ff;
				`OLU_OFF_ABS_MASK:   nxt_rdata = signal_absent_mask_ff;
				`OLU_OFF_SHORT_MASK: nxt_rdata = line_short_mask_ff;
				`OLU_OFF_ABS_IRQ:    nxt_rdata = signal_absent_irq_ff;
				`OLU_OFF_SHORT_IRQ:  nxt_rdata = line_short_irq_ff;
				`OLU_OFF_MON:        nxt_rdata = {4'h0, monitor_point_select_ff};
				`OLU_OFF_DLB:        nxt_rdata = digital_loopback_ctl_ff;
				`OLU_OFF_CRIT:       nxt_rdata = alarm_criteria_select_ff;
				`OLU_OFF_AUTO_ONES:  nxt_rdata = auto_all_ones_ctl_ff;
				default:             nxt_rdata = `OLU_RST_ZERO;
			endcase
		end
	end

	// every read strobe is answered one cycle later
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rdata_ff  <= `OLU_RST_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= REG_RD;
		end
	end

	// ------------------------------------------------------------------
	// monitor point decode
	// ------------------------------------------------------------------
	// channel code zero means off in both halves of the code space
	always_comb begin
		nxt_mon_kind = OLU_MON_OFF;
		if (monitor_point_select_ff[2:0] != 3'h0) begin
			nxt_mon_kind = monitor_point_select_ff[`OLU_MC_DIR_BIT]
				? OLU_MON_TX : OLU_MON_RX;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			mon_rx_ff <= 1'b0;
			mon_tx_ff <= 1'b0;
			mon_ch_ff <= 3'h0;
		end else begin
			mon_rx_ff <= (nxt_mon_kind == OLU_MON_RX);
			mon_tx_ff <= (nxt_mon_kind == OLU_MON_TX);
			mon_ch_ff <= monitor_point_select_ff[2:0];
		end
	end

	// ------------------------------------------------------------------
	// transmit all-ones
	// ------------------------------------------------------------------
	// manual request or loss with automatic mode; registered for timing
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST || srst) begin
			tx_ones_ff <= `OLU_RST_ZERO;
		end else begin
			tx_ones_ff <= all_ones_send_ctl_ff
				| (auto_all_ones_ctl_ff & signal_absent_status_ff);
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign REG_RDATA     = rdata_ff;
	assign REG_RVALID    = rvalid_ff;
	assign ANALOG_LB     = analog_loopback_ctl_ff;
	assign REMOTE_LB     = remote_loopback_ctl_ff;
	assign DIGITAL_LB    = digital_loopback_ctl_ff;
	assign ALARM_ETSI    = alarm_criteria_select_ff;
	assign TX_ALL_ONES   = tx_ones_ff;
	assign MON_RX_EN     = mon_rx_ff;
	assign MON_TX_EN     = mon_tx_ff;
	assign MON_CH        = mon_ch_ff;
	assign SOFT_RST_BUSY = rst_if.busy;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	rev_read_a: assert property (
		prim_rd && REG_ADDR == `OLU_OFF_REV |=> REG_RDATA == REVISION_CODE)
		else $error("revision code read wrong");
	alb_write_a: assert property (
		prim_wr && REG_ADDR == `OLU_OFF_ALB |=> ANALOG_LB == $past(REG_WDATA))
		else $error("analog loopback not written");
	rlb_write_a: assert property (
		prim_wr && REG_ADDR == `OLU_OFF_RLB |=> REMOTE_LB == $past(REG_WDATA))
		else $error("remote loopback not written");
	ones_out_a: assert property (
		!srst |=> (TX_ALL_ONES & $past(all_ones_send_ctl_ff))
			== $past(all_ones_send_ctl_ff))
		else $error("all-ones request not sent");
	abs_track_a: assert property (
		!srst |=> signal_absent_status_ff == $past(LOS_IN))
		else $error("loss status does not track input");
	short_track_a: assert property (
		!srst |=> line_short_status_ff == $past(SHORT_IN))
		else $error("short status does not track input");
	abs_mask_a: assert property (
		signal_absent_mask_ff == 8'h00 && signal_absent_irq_ff == 8'h00
			|=> signal_absent_irq_ff == 8'h00)
		else $error("masked loss flag set");
	short_mask_a: assert property (
		line_short_mask_ff == 8'h00 && line_short_irq_ff == 8'h00
			|=> line_short_irq_ff == 8'h00)
		else $error("masked short flag set");
	abs_set_a: assert property (
		!srst |=> (signal_absent_irq_ff & $past(abs_set)) == $past(abs_set))
		else $error("loss flag missed a change");
	abs_clear_a: assert property (
		rd_abs && abs_set == 8'h00 |=> signal_absent_irq_ff == 8'h00)
		else $error("loss flag not cleared by read");
	short_set_a: assert property (
		!srst |=> (line_short_irq_ff & $past(short_set)) == $past(short_set))
		else $error("short flag missed a change");
	srst_len_a: assert property (
		rst_if.start |=> SOFT_RST_BUSY ##124 SOFT_RST_BUSY ##1 !SOFT_RST_BUSY)
		else $error("soft reset length wrong");
	srst_dflt_a: assert property (
		srst |=> ANALOG_LB == 8'h00 && signal_absent_mask_ff == 8'h00
			&& bank_pointer_ff == `OLU_BANK_PRIMARY)
		else $error("soft reset left a register set");
	mon_code_a: assert property (
		prim_wr && REG_ADDR == `OLU_OFF_MON |=> ##1
			MON_TX_EN == ($past(REG_WDATA[3], 2) && $past(REG_WDATA[2:0], 2) != 0)
			&& MON_RX_EN == (!$past(REG_WDATA[3], 2)
			&& $past(REG_WDATA[2:0], 2) != 0))
		else $error("monitor decode wrong");
	dlb_write_a: assert property (
		prim_wr && REG_ADDR == `OLU_OFF_DLB |=> DIGITAL_LB == $past(REG_WDATA))
		else $error("digital loopback not written");
	crit_write_a: assert property (
		prim_wr && REG_ADDR == `OLU_OFF_CRIT |=> ALARM_ETSI == $past(REG_WDATA))
		else $error("criteria select not written");
	auto_ones_a: assert property (
		!srst |=> (TX_ALL_ONES & $past(auto_all_ones_ctl_ff
			& signal_absent_status_ff)) == $past(auto_all_ones_ctl_ff
			& signal_absent_status_ff))
		else $error("automatic all-ones missing");
	bank_hide_a: assert property (
		REG_WR && !prim_sel |=> ANALOG_LB == $past(ANALOG_LB)
			&& DIGITAL_LB == $past(DIGITAL_LB))
		else $error("write reached hidden bank");
	bit_map_a: assert property (
		prim_wr && REG_ADDR == `OLU_OFF_ALB |=> ANALOG_LB[0] == $past(REG_WDATA[0]))
		else $error("channel bit mapping wrong");

	srst_seen_c:  cover property (rst_if.start);
	abs_flag_c:   cover property (abs_set != 8'h00 ##[1:12] rd_abs);
	mon_tx_c:     cover property (MON_TX_EN && MON_CH == 3'h7);
	bank_swap_c:  cover property (bank_pointer_ff == `OLU_BANK_EXPANDED);

endmodule : olu_primary_regs

`default_nettype wire

/* File: src/olu_defs.svh */
// offsets, field positions, reset values and timing counts of the bank
`ifndef OLU_DEFS_SVH
`define OLU_DEFS_SVH

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define OLU_NCH            8
`define OLU_DW             8

// ----------------------------------------------------------------------
// register offsets, primary bank
// ----------------------------------------------------------------------
`define OLU_OFF_REV        8'h00
`define OLU_OFF_ALB        8'h01
`define OLU_OFF_RLB        8'h02
`define OLU_OFF_ONES       8'h03
`define OLU_OFF_ABS_ST     8'h04
`define OLU_OFF_SHORT_ST   8'h05
`define OLU_OFF_ABS_MASK   8'h06
`define OLU_OFF_SHORT_MASK 8'h07
`define OLU_OFF_ABS_IRQ    8'h08
`define OLU_OFF_SHORT_IRQ  8'h09
`define OLU_OFF_SRST       8'h0a
`define OLU_OFF_MON        8'h0b
`define OLU_OFF_DLB        8'h0c
`define OLU_OFF_CRIT       8'h0d
`define OLU_OFF_AUTO_ONES  8'h0e
`define OLU_OFF_BANK_PTR   8'h1f

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define OLU_RST_ZERO       8'h00
`define OLU_RST_SRST       8'hff
`define OLU_BANK_PRIMARY   8'h00
`define OLU_BANK_EXPANDED  8'haa
`define OLU_MC_W           4
`define OLU_MC_DIR_BIT     3
`define OLU_REV_DEFAULT    8'h5a // arbitrary value

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define OLU_CLK_MHZ        125
`define OLU_SRST_NS        1000
`define OLU_SRST_CYC       ((`OLU_SRST_NS * `OLU_CLK_MHZ) / 1000)
`define OLU_SRST_CW        7

`endif

/* File: src/olu_pkg.sv */
// types shared by the primary register bank modules
`default_nettype none

package olu_pkg;

	// soft reset timer states
	typedef enum logic {
		OLU_TMR_IDLE,
		OLU_TMR_RUN
	} olu_tmr_state_t;

	// what the monitor point looks at
	typedef enum logic [1:0] {
		OLU_MON_OFF,
		OLU_MON_RX,
		OLU_MON_TX
	} olu_mon_kind_t;

	typedef logic [7:0] olu_chan_t;

endpackage : olu_pkg

`default_nettype wire

/* File: src/olu_rst_if.sv */
// soft reset request and busy between register bank and its timer
`default_nettype none

interface olu_rst_if;
	logic start;
	logic busy;

	modport ctl (output start, input busy);
	modport tmr (input start, output busy);
endinterface : olu_rst_if

`default_nettype wire

/* File: src/olu_srst_tmr.sv */
// timer that holds the soft reset for its fixed duration
`include "olu_defs.svh"
`default_nettype none

module olu_srst_tmr
	import olu_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	olu_rst_if.tmr    rif
);

	localparam logic [`OLU_SRST_CW-1:0] LAST_CNT =
		`OLU_SRST_CW'(`OLU_SRST_CYC - 1);

	olu_tmr_state_t             state_ff;
	logic [`OLU_SRST_CW-1:0]    cnt_ff;

	// ------------------------------------------------------------------
	// state and count
	// ------------------------------------------------------------------
	// a start while running is ignored; the bank blocks writes then
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= OLU_TMR_IDLE;
			cnt_ff   <= '0;
		end else begin
			unique case (state_ff)
				OLU_TMR_IDLE: begin
					if (rif.start) begin
						state_ff <= OLU_TMR_RUN;
						cnt_ff   <= LAST_CNT;
					end
				end
				OLU_TMR_RUN: begin
					if (cnt_ff == '0) begin
						state_ff <= OLU_TMR_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 1'b1;
					end
				end
			endcase
		end
	end

	// busy straight from the state flop, so it is glitch free
	assign rif.busy = (state_ff == OLU_TMR_RUN);

endmodule : olu_srst_tmr

`default_nettype wire

/* File: tb/olu_line_model.sv */
// line side model: per-channel signal loss and short detector levels
`default_nettype none

module olu_line_model (
	input  wire logic       clk,
	output var  logic [7:0] loss,
	output var  logic [7:0] shrt
);
	timeunit 1ns;
	timeprecision 100ps;

	// detectors start quiet, as on a healthy line
	initial begin
		loss = 8'h00;
		shrt = 8'h00;
	end

	// levels move just after an edge, never on it, to keep sampling clean
	task automatic put(input logic [7:0] l, input logic [7:0] s);
		@(posedge clk);
		#1;
		loss = l;
		shrt = s;
	endtask : put
endmodule : olu_line_model

`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the primary register bank
`include "olu_defs.svh"
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] REV = 8'h3c; // arbitrary value
	logic       CLK_SYS, RST, REG_WR, REG_RD, REG_RVALID;
	logic       MON_RX_EN, MON_TX_EN, SOFT_RST_BUSY;
	logic [2:0] MON_CH;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, LOS_IN, SHORT_IN;
	logic [7:0] ANALOG_LB, REMOTE_LB, DIGITAL_LB, TX_ALL_ONES, ALARM_ETSI;
	logic [7:0] exp_q[$];
	logic [7:0] vals [8];
	logic [7:0] offs [8] = '{8'h01, 8'h02, 8'h03, 8'h06,
		8'h07, 8'h0c, 8'h0d, 8'h0e};
	logic [7:0] l0, s0, l1, s1, m, k;
	int         err_count = 0;
	int         n_tests   = 0;
	int         seed      = 50906;
	int         n;

	olu_primary_regs #(.REVISION_CODE(REV)) dut (
		.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.LOS_IN(LOS_IN), .SHORT_IN(SHORT_IN), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID), .ANALOG_LB(ANALOG_LB),
		.REMOTE_LB(REMOTE_LB), .DIGITAL_LB(DIGITAL_LB),
		.TX_ALL_ONES(TX_ALL_ONES), .ALARM_ETSI(ALARM_ETSI),
		.MON_RX_EN(MON_RX_EN), .MON_TX_EN(MON_TX_EN), .MON_CH(MON_CH),
		.SOFT_RST_BUSY(SOFT_RST_BUSY));

	olu_line_model line (.clk(CLK_SYS), .loss(LOS_IN), .shrt(SHORT_IN));

	// ------------------------------------------------------------------
	// clock and bus tasks
	// ------------------------------------------------------------------
	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	task automatic cmp(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// strobes rise and fall 1ns after an edge, held across one edge
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge CLK_SYS);
		#1;
		REG_ADDR  = ad;
		REG_WDATA = d;
		REG_WR    = 1'b1;
		@(posedge CLK_SYS);
		#1;
		REG_WR = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge CLK_SYS);
		#1;
		REG_ADDR = ad;
		REG_RD   = 1'b1;
		@(posedge CLK_SYS);
		#1;
		REG_RD = 1'b0;
	endtask : rd

	// fixed wait covers the two-stage paths to the level outputs
	task automatic settle;
		repeat (3) @(posedge CLK_SYS);
		#1;
	endtask : settle

	task automatic wrap_up;
		if (exp_q.size() != 0)
			cmp("reads left", 8'h00, 8'(exp_q.size()));
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// read answers are matched in order against the noted expectations
	always @(posedge CLK_SYS) begin
		if (REG_RVALID === 1'b1)
			cmp("read data", exp_q.size() ? exp_q.pop_front() : 8'hxx,
				REG_RDATA);
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		RST = 1'b1;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		repeat (8) @(posedge CLK_SYS);
		#1;
		RST = 1'b0;
		// defaults, incl. write-only, unmapped and pointer offsets
		for (int i = 0; i < 16; i++)
			rd(8'(i), i == 0 ? REV : 8'h00);
		rd(8'h1f, 8'h00);
		// control registers: random write, read back, outputs follow
		for (int i = 0; i < 8; i++) begin
			vals[i] = 8'($random(seed));
			wr(offs[i], vals[i]);
			rd(offs[i], vals[i]);
		end
		settle();
		cmp("analog", vals[0], ANALOG_LB);
		cmp("remote", vals[1], REMOTE_LB);
		cmp("all ones", vals[2], TX_ALL_ONES);
		cmp("digital", vals[5], DIGITAL_LB);
		cmp("criteria", vals[6], ALARM_ETSI);
		// every monitor code; upper nibble kept clear
		for (int c = 0; c < 16; c++) begin
			wr(8'h0b, 8'(c));
			settle();
			cmp("mon rx", {7'h00, c[2:0] != 0 && !c[3]},
				{7'h00, MON_RX_EN});
			cmp("mon tx", {7'h00, c[2:0] != 0 && c[3]},
				{7'h00, MON_TX_EN});
			cmp("mon ch", {5'h00, c[2:0]}, {5'h00, MON_CH});
			rd(8'h0b, 8'(c));
		end
		// line changes under random masks; flags clear on status read
		l0 = 8'h00;
		s0 = 8'h00;
		for (int i = 0; i < 6; i++) begin
			m = 8'($random(seed));
			k = 8'($random(seed));
			wr(8'h06, m);
			wr(8'h07, k);
			l1 = 8'($random(seed));
			s1 = 8'($random(seed));
			line.put(l1, s1);
			settle();
			cmp("tx ones", vals[2] | (vals[7] & l1),
				TX_ALL_ONES);
			rd(8'h08, (l1 ^ l0) & m);
			rd(8'h09, (s1 ^ s0) & k);
			rd(8'h04, l1);
			rd(8'h08, 8'h00);
			rd(8'h05, s1);
			rd(8'h09, 8'h00);
			l0 = l1;
			s0 = s1;
		end
		// expanded bank selected: primary offsets refused
		wr(8'h1f, `OLU_BANK_EXPANDED);
		rd(8'h01, 8'h00);
		wr(8'h01, ~vals[0]);
		wr(8'h1f, `OLU_BANK_PRIMARY);
		rd(8'h01, vals[0]);
		// soft reset: busy length, then everything back at default
		wr(8'h0a, 8'($random(seed)));
		n = 0;
		while (SOFT_RST_BUSY === 1'b1 && n < 400) begin
			@(posedge CLK_SYS);
			#1;
			n++;
		end
		cmp("busy cycles", 8'(`OLU_SRST_CYC), 8'(n));
		settle();
		cmp("analog", 8'h00, ANALOG_LB);
		cmp("all ones", 8'h00, TX_ALL_ONES);
		// monitor code was left at transmitter seven before the reset
		cmp("mon tx rst", 8'h00, {7'h00, MON_TX_EN});
		cmp("mon ch rst", 8'h00, {5'h00, MON_CH});
		for (int i = 0; i < 8; i++)
			rd(offs[i], 8'h00);
		rd(8'h00, REV);
		rd(8'h04, l0);
		rd(8'h08, 8'h00);
		// mid-run hard reset: control register clears while it is held
		wr(8'h01, 8'hff);
		RST = 1'b1;
		settle();
		cmp("analog hard rst", 8'h00, ANALOG_LB);
		RST = 1'b0;
		rd(8'h01, 8'h00);
		settle();
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
